// ### core/flash_status_write_latch.sv
// Status registers, write latch and command front end of the serial flash
`include "flash_status_params.svh"

module flash_status_write_latch (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        linkClk,
  input  wire logic        chipSel_n,
  input  wire logic [3:0]  ioPinIn,
  output logic      [3:0]  ioPinOut,
  output logic      [3:0]  ioPinOe_n,
  input  wire logic        protectPin_n,
  output logic      [15:0] statusOut,
  output logic             quadMode,
  output logic             fourWireMode,
  output logic             secureHit,
  output logic      [1:0]  secureIndex,
  output logic      [9:0]  secureOffset,
  output logic             secureReadOnly,
  output logic             chipEraseAllowed
);
  link_bus_if lk ();
  flash_status_pkg::phase_t phase_r;

  logic [15:0] status_r;
  logic [7:0]  shiftIn_r;
  logic [3:0]  bitCnt_r;
  logic [7:0]  opcode_r;
  logic [15:0] wrData_r;
  logic [4:0]  wrBits_r;
  logic [23:0] addr_r;
  logic [4:0]  addrCnt_r;
  logic [7:0]  outByte_r;
  logic [2:0]  outBit_r;
  logic        volArm_r;
  logic        resetArm_r;
  logic        eraseOp_r;
  logic        inFrame_r;
  logic        quadIo_r;
  logic        qpi_r;
  logic [15:0] nvImage_r;
  logic        busy;
  logic        cycleDone;
  logic        cycleStart;
  logic        opDone;
  logic [7:0]  nextByte;
  logic        byteDone;
  logic        modeLocked;
  logic        wantsLatch;
  logic        isErase;
  logic        isProgram;

  link_front u_front (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .linkClk      (linkClk),
    .chipSel_n    (chipSel_n),
    .ioPinIn      (ioPinIn),
    .protectPin_n (protectPin_n),
    .lk           (lk)
  );

  busy_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (cycleStart),
    .busy    (busy),
    .done    (cycleDone)
  );

  always_comb begin
    if (qpi_r || (quadIo_r && phase_r != flash_status_pkg::PH_OPCODE)) begin
      nextByte = {shiftIn_r[3:0], lk.ioIn};
      byteDone = (bitCnt_r == 4'h1);
    end else begin
      nextByte = {shiftIn_r[6:0], lk.ioIn[0]};
      byteDone = (bitCnt_r == 4'h7);
    end
  end

  assign modeLocked = (status_r[`BIT_MODE_HI])
                    | (~status_r[`BIT_MODE_HI] & status_r[`BIT_MODE_LO]
                       & ~lk.protectPin);
  assign isErase = (opcode_r == `OP_PAGE_ERASE)
                 | (opcode_r == `OP_SECTOR_ERASE)
                 | (opcode_r == `OP_BLOCK32_ERASE)
                 | (opcode_r == `OP_BLOCK_ERASE)
                 | (opcode_r == `OP_SECURE_ERASE)
                 | (opcode_r == `OP_CHIP_ERASE_A)
                 | (opcode_r == `OP_CHIP_ERASE_B);
  assign isProgram = (opcode_r == `OP_PAGE_PROGRAM)
                   | (opcode_r == `OP_QUAD_PROGRAM)
                   | (opcode_r == `OP_BUFFER_COMMIT)
                   | (opcode_r == `OP_SECURE_PROGRAM);
  assign wantsLatch = isErase | isProgram
                    | (opcode_r == `OP_STATUS_WR)
                    | (opcode_r == `OP_STATUS_WR_HI)
                    | (opcode_r == `OP_CONFIG_WR);
  assign chipEraseAllowed = (status_r[6:2] == `PROTECT_NONE);

  assign cycleStart = lk.frameEnd && !busy && wantsLatch
                    && status_r[`BIT_LATCH] && opcode_r != 8'h00
                    && !((opcode_r == `OP_CHIP_ERASE_A
                          || opcode_r == `OP_CHIP_ERASE_B)
                         && !chipEraseAllowed)
                    && !((opcode_r == `OP_STATUS_WR
                          || opcode_r == `OP_STATUS_WR_HI)
                         && (modeLocked
                             || (wrBits_r != 5'd8 && wrBits_r != 5'd16)));
  assign opDone = cycleDone;

  // Command phase tracking
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r   <= flash_status_pkg::PH_OPCODE;
      shiftIn_r <= 8'h00;
      bitCnt_r  <= 4'h0;
      opcode_r  <= 8'h00;
      wrData_r  <= 16'h0000;
      wrBits_r  <= 5'd0;
      addr_r    <= 24'h000000;
      addrCnt_r <= 5'd0;
    end else if (lk.frameStart) begin
      phase_r   <= flash_status_pkg::PH_OPCODE;
      bitCnt_r  <= 4'h0;
      opcode_r  <= 8'h00;
      wrBits_r  <= 5'd0;
      addrCnt_r <= 5'd0;
    end else if (lk.riseEdge) begin
      case (phase_r)
        flash_status_pkg::PH_OPCODE: begin
          shiftIn_r <= nextByte;
          bitCnt_r  <= byteDone ? 4'h0 : bitCnt_r + 4'h1;
          if (byteDone) begin
            opcode_r <= nextByte;
            if (nextByte == `OP_STATUS_RD_LO
                || nextByte == `OP_STATUS_RD_HI) begin
              phase_r <= flash_status_pkg::PH_READOUT;
            end else if (nextByte == `OP_STATUS_WR
                         || nextByte == `OP_STATUS_WR_HI) begin
              phase_r <= flash_status_pkg::PH_DATA_IN;
            end else if (nextByte == `OP_SECURE_PROGRAM
                         || nextByte == `OP_SECURE_ERASE) begin
              phase_r <= flash_status_pkg::PH_ADDR;
            end else begin
              phase_r <= flash_status_pkg::PH_IGNORE;
            end
          end
        end
        flash_status_pkg::PH_ADDR: begin
          if (qpi_r) begin
            addr_r    <= {addr_r[19:0], lk.ioIn};
            addrCnt_r <= addrCnt_r + 5'd4;
          end else begin
            addr_r    <= {addr_r[22:0], lk.ioIn[0]};
            addrCnt_r <= addrCnt_r + 5'd1;
          end
          if (addrCnt_r >= 5'd20 && (qpi_r || addrCnt_r == 5'd23)) begin
            phase_r <= flash_status_pkg::PH_IGNORE;
          end
        end
        flash_status_pkg::PH_DATA_IN: begin
          if (wrBits_r < 5'd16) begin
            wrData_r <= qpi_r ? {wrData_r[11:0], lk.ioIn}
                              : {wrData_r[14:0], lk.ioIn[0]};
            wrBits_r <= wrBits_r + (qpi_r ? 5'd4 : 5'd1);
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    secureHit   = (addr_r[23:16] == `SECURE_HI_BYTE)
                && (addr_r[15:10] == `SECURE_SEL_1
                    || addr_r[15:10] == `SECURE_SEL_2
                    || addr_r[15:10] == `SECURE_SEL_3);
    secureIndex = addr_r[13:12];
    secureOffset = addr_r[9:0];
  end
  assign secureReadOnly = secureHit && secureIndex != 2'h0
                        && status_r[`BIT_LOCK_LO + 32'(secureIndex) - 1];

  // Quad and four-wire mode control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qpi_r    <= 1'b0;
      quadIo_r <= 1'b0;
    end else if (lk.frameEnd) begin
      if (opcode_r == `OP_QPI_ENTER && status_r[`BIT_QUAD]) begin
        qpi_r <= 1'b1;
      end else if (opcode_r == `OP_QPI_EXIT) begin
        qpi_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      volArm_r   <= 1'b0;
      resetArm_r <= 1'b0;
    end else if (lk.frameEnd && opcode_r != 8'h00) begin
      volArm_r   <= (opcode_r == `OP_VOL_ENABLE);
      resetArm_r <= (opcode_r == `OP_RESET_ENABLE);
    end
  end

  // Kind of running cycle, for suspend
  // Suspend frame overwrites opcode_r first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eraseOp_r <= 1'b0;
    end else if (cycleStart) begin
      eraseOp_r <= isErase;
    end
  end

  // Synchronised frame; raw select never read
  // Pins release a few clocks after select rises
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inFrame_r <= 1'b0;
    end else if (lk.frameStart) begin
      inFrame_r <= 1'b1;
    end else if (lk.frameEnd) begin
      inFrame_r <= 1'b0;
    end
  end

  // Status register updates
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_r  <= `STATUS_RESET;
      nvImage_r <= `STATUS_RESET;
    end else begin
      status_r[`BIT_BUSY] <= busy | cycleStart;
      if (lk.frameEnd && opcode_r == `OP_LATCH_SET && !busy) begin
        status_r[`BIT_LATCH] <= 1'b1;
      end else if (lk.frameEnd && (opcode_r == `OP_LATCH_CLEAR
                   || (resetArm_r && opcode_r == `OP_RESET))) begin
        status_r[`BIT_LATCH] <= 1'b0;
      end else if (opDone) begin
        status_r[`BIT_LATCH] <= 1'b0;
      end
      if (lk.frameEnd && opcode_r == `OP_SUSPEND && busy) begin
        status_r[`BIT_ERASE_SUSP] <= eraseOp_r;
        status_r[`BIT_PROG_SUSP]  <= ~eraseOp_r;
      end else if (lk.frameEnd && opcode_r == `OP_RESUME) begin
        status_r[`BIT_ERASE_SUSP] <= 1'b0;
        status_r[`BIT_PROG_SUSP]  <= 1'b0;
      end
      if (cycleStart && (opcode_r == `OP_STATUS_WR)) begin
        status_r[6:2]               <= wrData_r[(wrBits_r == 5'd16) ? 14 : 6
                                               -: 5];
        status_r[`BIT_MODE_LO]      <= wrBits_r == 5'd16 ? wrData_r[15]
                                                         : wrData_r[7];
        if (wrBits_r == 5'd16) begin
          status_r[`BIT_MODE_HI]    <= wrData_r[0];
          status_r[`BIT_QUAD]       <= wrData_r[1];
          status_r[`BIT_COMPLEMENT] <= wrData_r[6];
          status_r[`BIT_LOCK_HI:`BIT_LOCK_LO] <=
            status_r[`BIT_LOCK_HI:`BIT_LOCK_LO] | wrData_r[5:3];
        end else begin
          status_r[`BIT_MODE_HI]    <= 1'b0;
          status_r[`BIT_QUAD]       <= 1'b0;
          status_r[`BIT_COMPLEMENT] <= 1'b0;
        end
      end else if (cycleStart && opcode_r == `OP_STATUS_WR_HI) begin
        status_r[`BIT_MODE_HI]    <= wrData_r[0];
        status_r[`BIT_QUAD]       <= wrData_r[1];
        status_r[`BIT_COMPLEMENT] <= wrData_r[6];
        status_r[`BIT_LOCK_HI:`BIT_LOCK_LO] <=
          status_r[`BIT_LOCK_HI:`BIT_LOCK_LO] | wrData_r[5:3];
      end
      // Nonvolatile copy takes status_r from before the update at each cycle start not marked volatile
      if (cycleStart && !volArm_r) begin
        nvImage_r <= status_r;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outByte_r  <= 8'h00;
      outBit_r   <= 3'h7;
    end else if (lk.frameStart) begin
      outBit_r <= 3'h7;
    end else if (phase_r == flash_status_pkg::PH_READOUT && lk.fallEdge) begin
      if (outBit_r == 3'h7) begin
        outByte_r <= (opcode_r == `OP_STATUS_RD_HI) ? status_r[15:8]
                                                    : status_r[7:0];
      end
      outBit_r <= qpi_r ? outBit_r - 3'h4 : outBit_r - 3'h1;
    end
  end

  always_comb begin
    ioPinOut  = 4'h0;
    ioPinOe_n = 4'hf;
    if (phase_r == flash_status_pkg::PH_READOUT && inFrame_r) begin
      if (qpi_r) begin
        ioPinOut  = outBit_r[2] ? outByte_r[3:0] : outByte_r[7:4];
        ioPinOe_n = 4'h0;
      end else begin
        ioPinOut[1]  = outByte_r[3'(outBit_r + 3'h1)];
        ioPinOe_n[1] = 1'b0;
      end
    end
  end

  assign quadMode     = status_r[`BIT_QUAD];
  assign fourWireMode = qpi_r;
  assign statusOut    = status_r;
endmodule

// ### core/flash_status_params.svh
// Opcodes, status bit positions and timing counts of the status block
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH
`define OP_LATCH_SET      8'h06
`define OP_LATCH_CLEAR    8'h04
`define OP_VOL_ENABLE     8'h50
`define OP_STATUS_RD_LO   8'h05
`define OP_STATUS_RD_HI   8'h35
`define OP_STATUS_WR      8'h01
`define OP_STATUS_WR_HI   8'h31
`define OP_CONFIG_WR      8'h11
`define OP_PAGE_PROGRAM   8'h02
`define OP_QUAD_PROGRAM   8'h32
`define OP_PAGE_ERASE     8'h81
`define OP_SECTOR_ERASE   8'h20
`define OP_BLOCK32_ERASE  8'h52
`define OP_BLOCK_ERASE    8'hd8
`define OP_CHIP_ERASE_A   8'h60
`define OP_CHIP_ERASE_B   8'hc7
`define OP_BUFFER_COMMIT  8'h9d
`define OP_SECURE_ERASE   8'h44
`define OP_SECURE_PROGRAM 8'h42
`define OP_SUSPEND        8'h75
`define OP_RESUME         8'h7a
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
`define OP_QPI_ENTER      8'h38
`define OP_QPI_EXIT       8'hff
`define BIT_BUSY          0
`define BIT_LATCH         1
`define BIT_MODE_LO       7
`define BIT_MODE_HI       8
`define BIT_QUAD          9
`define BIT_PROG_SUSP     10
`define BIT_LOCK_LO       11
`define BIT_LOCK_HI       13
`define BIT_COMPLEMENT    14
`define BIT_ERASE_SUSP    15
`define STATUS_RESET      16'h0000
`define PROTECT_NONE      5'h00
`define SECURE_HI_BYTE    8'h00
`define SECURE_SEL_1      6'h04
`define SECURE_SEL_2      6'h08
`define SECURE_SEL_3      6'h0c
`define WRITE_TIME_NS     5000
`define CLK_PERIOD_NS     5
`define WRITE_CYCLES      (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`define BUSY_CNT_W        12
`endif

// ### core/flash_status_pkg.sv
// Types shared by the status block modules
package flash_status_pkg;
  typedef enum logic [2:0] {
    PH_OPCODE  = 3'b000,
    PH_ADDR    = 3'b001,
    PH_DATA_IN = 3'b011,
    PH_READOUT = 3'b010,
    PH_IGNORE  = 3'b110
  } phase_t;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_BUSY = 2'b01
  } busy_state_t;
endpackage

// ### core/link_bus_if.sv
// Sampled link events passed from the front end to the command logic
interface link_bus_if;
  logic       frameStart;
  logic       frameEnd;
  logic       riseEdge;
  logic       fallEdge;
  logic [3:0] ioIn;
  logic       protectPin;
  modport front (output frameStart, frameEnd, riseEdge, fallEdge, ioIn,
                 output protectPin);
  modport core  (input frameStart, frameEnd, riseEdge, fallEdge, ioIn,
                 input protectPin);
endinterface

// ### core/link_front.sv
// Synchronisers and edge detection for the serial link pins
module link_front (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic linkClk,
  input  wire logic chipSel_n,
  input  wire logic [3:0] ioPinIn,
  input  wire logic protectPin_n,
  link_bus_if.front lk
);
  logic [1:0] clkSync;
  logic [1:0] csSync;
  logic [3:0] ioSync0;
  logic [3:0] ioSync1;
  logic [1:0] wpSync;
  logic       clkPrev;
  logic       csPrev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkSync <= 2'h0;
      csSync  <= 2'h3;
      ioSync0 <= 4'h0;
      ioSync1 <= 4'h0;
      wpSync  <= 2'h3;
      clkPrev <= 1'b0;
      csPrev  <= 1'b1;
    end else begin
      clkSync <= {clkSync[0], linkClk};
      csSync  <= {csSync[0], chipSel_n};
      ioSync0 <= ioPinIn;
      ioSync1 <= ioSync0;
      wpSync  <= {wpSync[0], protectPin_n};
      clkPrev <= clkSync[1];
      csPrev  <= csSync[1];
    end
  end

  // Edges only count inside a frame
  assign lk.riseEdge   = clkSync[1] & ~clkPrev & ~csSync[1];
  assign lk.fallEdge   = ~clkSync[1] & clkPrev & ~csSync[1];
  assign lk.frameStart = ~csSync[1] & csPrev;
  assign lk.frameEnd   = csSync[1] & ~csPrev;
  assign lk.ioIn       = ioSync1;
  assign lk.protectPin = wpSync[1];
endmodule

// ### core/busy_timer.sv
// Self-timed write cycle: holds busy for a fixed count after a start pulse
`include "flash_status_params.svh"
module busy_timer #(
  parameter int CYCLES = `WRITE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  flash_status_pkg::busy_state_t state_r;
  logic [`BUSY_CNT_W-1:0] count_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= flash_status_pkg::OP_IDLE;
      count_r <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        flash_status_pkg::OP_IDLE: begin
          if (start) begin
            state_r <= flash_status_pkg::OP_BUSY;
            count_r <= `BUSY_CNT_W'(CYCLES - 1);
          end
        end
        default: begin
          if (count_r == '0) begin
            state_r <= flash_status_pkg::OP_IDLE;
            done    <= 1'b1;
          end else begin
            count_r <= count_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign busy = (state_r == flash_status_pkg::OP_BUSY);
endmodule

// ### sim/flash_status_checker_assertions.sv
// Port-level assertions for the status and write latch block
`include "flash_status_params.svh"
module flash_status_checker (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        linkClk,
  input  wire logic        chipSel_n,
  input  wire logic [3:0]  ioPinIn,
  input  wire logic [3:0]  ioPinOut,
  input  wire logic [3:0]  ioPinOe_n,
  input  wire logic        protectPin_n,
  input  wire logic [15:0] statusOut,
  input  wire logic        quadMode,
  input  wire logic        fourWireMode,
  input  wire logic        secureHit,
  input  wire logic [1:0]  secureIndex,
  input  wire logic [9:0]  secureOffset,
  input  wire logic        secureReadOnly,
  input  wire logic        chipEraseAllowed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int busyLen_r;
  // Loose ceiling, twice the fixed write cycle; suspend does not stop the timer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busyLen_r <= 0;
    else if (statusOut[`BIT_BUSY]) busyLen_r <= busyLen_r + 1;
    else busyLen_r <= 0;
  end
  chk_erase_gate: assert property (
    $stable(statusOut[6:2]) [*2] |->
      chipEraseAllowed == (statusOut[6:2] == 5'h00))
    else $error("chip erase permit disagrees with level bits");
  chk_quad_pins: assert property (
    $stable(statusOut[9]) [*2] |-> quadMode == statusOut[9])
    else $error("quad mode disagrees with quad bit");
  chk_busy_min: assert property (
    $rose(statusOut[0]) |-> statusOut[0] [*8])
    else $error("busy flag dropped too early");
  chk_busy_max: assert property (
    busyLen_r <= 2 * `WRITE_CYCLES)
    else $error("busy flag stuck high");
  chk_latch_frame: assert property (
    $rose(statusOut[1]) |-> chipSel_n)
    else $error("latch set inside a frame");
  chk_release_idle: assert property (
    chipSel_n [*6] |-> ioPinOe_n == 4'hf)
    else $error("pins driven while deselected");
  chk_spi_lines: assert property (
    !fourWireMode |-> ioPinOe_n[3:2] == 2'b11 && ioPinOe_n[0])
    else $error("unused line driven in single-wire mode");
  chk_locks_keep: assert property (
    !$fell(statusOut[11]) && !$fell(statusOut[12]) && !$fell(statusOut[13]))
    else $error("lock bit cleared");
  chk_otp_mode: assert property (
    statusOut[8:7] == 2'b11 |=> statusOut[8:7] == 2'b11)
    else $error("permanent protect mode left");
  chk_susp_frame: assert property (
    (!chipSel_n) [*8] |-> $stable(statusOut[15]) && $stable(statusOut[10]))
    else $error("suspend flag changed inside a frame");
endmodule

bind flash_status_write_latch flash_status_checker flash_status_checker_i (
  .sys_clk(sys_clk),
  .rst(rst),
  .linkClk(linkClk),
  .chipSel_n(chipSel_n),
  .ioPinIn(ioPinIn),
  .ioPinOut(ioPinOut),
  .ioPinOe_n(ioPinOe_n),
  .protectPin_n(protectPin_n),
  .statusOut(statusOut),
  .quadMode(quadMode),
  .fourWireMode(fourWireMode),
  .secureHit(secureHit),
  .secureIndex(secureIndex),
  .secureOffset(secureOffset),
  .secureReadOnly(secureReadOnly),
  .chipEraseAllowed(chipEraseAllowed)
);

// ### sim/spi_host_model.sv
// Host serial controller model that frames commands on the flash link
module spi_host_model (
  input  wire logic       sysClk,
  output logic            linkClk,
  output logic            chipSel_n,
  output logic      [3:0] ioPinIn,
  input  wire logic [3:0] ioPinOut,
  input  wire logic [3:0] ioPinOe_n,
  output logic      [7:0] rdByte
);
  timeunit 1ns;
  timeprecision 100ps;
  event gotByte;
  initial begin
    linkClk = 1'b0;
    chipSel_n = 1'b1;
    ioPinIn = 4'h5;
    rdByte = 8'h00;
  end
  task automatic sel();
    @(negedge sysClk);
    #1 chipSel_n = 1'b0;
  endtask
  task automatic desel();
    #62.5 chipSel_n = 1'b1;
    ioPinIn = ~ioPinIn;
    #250;
  endtask
  // Unused lines toggle so stale values never pass
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ioPinIn = {~ioPinIn[3:1], b[i]};
      #62.5 linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
  endtask
  task automatic get();
    for (int i = 7; i >= 0; i--) begin
      ioPinIn = ~ioPinIn;
      #62.5 linkClk = 1'b1;
      rdByte[i] = ioPinOe_n[1] ? 1'bx : ioPinOut[1];
      #62.5 linkClk = 1'b0;
    end
    -> gotByte;
  endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the status and write latch block
`include "flash_status_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sysClk;
  logic        rst;
  logic        protectPin_n;
  logic        linkClk;
  logic        chipSel_n;
  logic [3:0]  ioPinIn;
  logic [3:0]  ioPinOut;
  logic [3:0]  ioPinOe_n;
  logic [15:0] statusOut;
  logic        quadMode;
  logic        fourWireMode;
  logic        secureHit;
  logic [1:0]  secureIndex;
  logic [9:0]  secureOffset;
  logic        secureReadOnly;
  logic        chipEraseAllowed;
  logic [7:0]  rdByte;
  logic [7:0]  expQ[$];
  logic [31:0] seed = 32'h7ea8;
  int          miscompares = 0;
  int          comparisons = 0;

  flash_status_write_latch flash_status_write_latch_i (
    .sys_clk(sysClk), .rst(rst), .linkClk(linkClk),
    .chipSel_n(chipSel_n), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut),
    .ioPinOe_n(ioPinOe_n), .protectPin_n(protectPin_n),
    .statusOut(statusOut), .quadMode(quadMode),
    .fourWireMode(fourWireMode), .secureHit(secureHit),
    .secureIndex(secureIndex), .secureOffset(secureOffset),
    .secureReadOnly(secureReadOnly), .chipEraseAllowed(chipEraseAllowed)
  );
  spi_host_model spi_host_model_i (
    .sysClk(sysClk), .linkClk(linkClk), .chipSel_n(chipSel_n),
    .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOe_n(ioPinOe_n),
    .rdByte(rdByte)
  );

  initial begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    spi_host_model_i.sel();
    spi_host_model_i.put(op);
    spi_host_model_i.desel();
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] e, input int n);
    spi_host_model_i.sel();
    spi_host_model_i.put(op);
    repeat (n) begin
      expQ.push_back(e);
      spi_host_model_i.get();
    end
    spi_host_model_i.desel();
  endtask
  task automatic wr(input logic [7:0] lo, input logic [7:0] hi, input bit two);
    spi_host_model_i.sel();
    spi_host_model_i.put(`OP_STATUS_WR);
    spi_host_model_i.put(lo);
    if (two) spi_host_model_i.put(hi);
    spi_host_model_i.desel();
  endtask
  task automatic addr(input logic [7:0] op, input logic [7:0] mid,
                      input logic [7:0] low, input bit data);
    spi_host_model_i.sel();
    spi_host_model_i.put(op);
    spi_host_model_i.put(8'h00);
    spi_host_model_i.put(mid);
    spi_host_model_i.put(low);
    if (data) spi_host_model_i.put(8'h5a);
    spi_host_model_i.desel();
  endtask
  task automatic idle();
    for (int n = 0; n < 1500 && statusOut[`BIT_BUSY] !== 1'b0; n++)
      @(negedge sysClk);
    chk({15'h0000, statusOut[`BIT_BUSY]}, 16'h0000);
    repeat (10) @(negedge sysClk);
  endtask
  task automatic reset_dut();
    rst = 1'b1;
    repeat (12) @(negedge sysClk);
    rst = 1'b0;
    repeat (8) @(negedge sysClk);
  endtask

  always @(spi_host_model_i.gotByte) begin
    chk({8'h00, rdByte}, {8'h00, expQ.pop_front()});
  end

  initial begin
    #450000;
    miscompares++;
    close_out();
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  lo;
    logic [7:0]  hi;
    protectPin_n = 1'b1;
    reset_dut();
    rd(`OP_STATUS_RD_LO, 8'h00, 1);
    rd(`OP_STATUS_RD_HI, 8'h00, 1);
    cmd(`OP_LATCH_SET);
    rd(`OP_STATUS_RD_LO, 8'h02, 2);
    cmd(`OP_LATCH_CLEAR);
    rd(`OP_STATUS_RD_LO, 8'h00, 1);
    cmd(`OP_LATCH_SET);
    cmd(`OP_RESET_ENABLE);
    cmd(`OP_RESET);
    rd(`OP_STATUS_RD_LO, 8'h00, 1);
    wr(8'hfc, 8'h42, 1'b1);
    idle();
    rd(`OP_STATUS_RD_LO, 8'h00, 1);
    repeat (3) begin
      r = rnd();
      lo = r[7:0] & 8'h7c;
      hi = r[15:8] & 8'h42;
      cmd(`OP_LATCH_SET);
      wr(lo | 8'h03, hi | 8'h84, 1'b1);
      chk({14'h0000, statusOut[1:0]}, 16'h0003);
      idle();
      rd(`OP_STATUS_RD_LO, lo, 1);
      rd(`OP_STATUS_RD_HI, hi, 1);
      chk({15'h0000, quadMode}, {15'h0000, hi[1]});
      chk({15'h0000, chipEraseAllowed}, {15'h0000, lo[6:2] == 5'h00});
    end
    cmd(`OP_LATCH_SET);
    wr(8'h20, 8'h00, 1'b0);
    idle();
    rd(`OP_STATUS_RD_HI, 8'h00, 1);
    cmd(`OP_LATCH_SET);
    wr(8'h80, 8'h00, 1'b1);
    idle();
    protectPin_n = 1'b0;
    cmd(`OP_LATCH_SET);
    wr(8'h84, 8'h00, 1'b1);
    idle();
    cmd(`OP_LATCH_CLEAR);
    rd(`OP_STATUS_RD_LO, 8'h80, 1);
    @(negedge sysClk);
    protectPin_n = 1'b1;
    cmd(`OP_LATCH_SET);
    wr(8'h08, 8'h00, 1'b1);
    idle();
    rd(`OP_STATUS_RD_LO, 8'h08, 1);
    cmd(`OP_LATCH_SET);
    cmd(`OP_VOL_ENABLE);
    wr(8'h00, 8'h00, 1'b1);
    idle();
    rd(`OP_STATUS_RD_LO, 8'h00, 1);
    for (int k = 0; k < 2; k++) begin
      cmd(`OP_LATCH_SET);
      addr(k ? `OP_SECTOR_ERASE : `OP_PAGE_PROGRAM, 8'h01, 8'h00, k == 0);
      rd(`OP_STATUS_RD_LO, 8'h03, 1);
      cmd(`OP_SUSPEND);
      rd(`OP_STATUS_RD_HI, k ? 8'h80 : 8'h04, 1);
      cmd(`OP_RESUME);
      rd(`OP_STATUS_RD_HI, 8'h00, 1);
      idle();
      rd(`OP_STATUS_RD_LO, 8'h00, 1);
    end
    cmd(`OP_LATCH_SET);
    wr(8'h80, 8'h09, 1'b1);
    idle();
    cmd(`OP_LATCH_SET);
    wr(8'h00, 8'h00, 1'b1);
    idle();
    rd(`OP_STATUS_RD_HI, 8'h09, 1);
    for (int i = 1; i < 4; i++) begin
      cmd(`OP_LATCH_SET);
      addr(`OP_SECURE_PROGRAM, {6'(i * 4), 2'b10}, 8'h34, 1'b1);
      chk({secureHit, secureReadOnly, secureIndex, 2'b00, secureOffset},
          {1'b1, 1'(i == 1), 2'(i), 2'b00, 10'h234});
      idle();
    end
    reset_dut();
    chk(statusOut, `STATUS_RESET);
    cmd(`OP_LATCH_SET);
    wr(8'h00, 8'h02, 1'b1);
    idle();
    cmd(`OP_QPI_ENTER);
    chk({14'h0000, fourWireMode, quadMode}, 16'h0003);
    close_out();
  end
endmodule
